// [bilu_regs.vh]
// register map and field constants of the board interrupt latch unit
// assumes a 32-bit AXI4-Lite slave with byte addresses
`ifndef BILU_REGS_VH
`define BILU_REGS_VH
`define BILU_ADDR_W       6
`define BILU_NSRC         12
`define BILU_OFS_ENABLE   6'h28
`define BILU_OFS_STATUS   6'h2C
`define BILU_OFS_LATCH    6'h30
`define BILU_RESET_VAL    12'h000
`define BILU_RESP_OKAY    2'h0
`define BILU_RESP_SLVERR  2'h2
`define BILU_BIT_TEMP     0
`define BILU_BIT_SYSMON   1
`define BILU_BIT_PORTA    2
`define BILU_BIT_PORTB    3
`define BILU_BIT_CUSTOM   4
`endif

// [bilu_top.v]
// board interrupt latch unit: live status, latches, enables, pulse output
// assumes all inputs synchronous to clk; AXI4-Lite master on the csr port
// irq is a one-cycle pulse; software finds the cause in the latch word
// Operation
// - latch register at 0x30, twelve bits
// - latch bit reads one when captured
// - write one clears that latch only
// - bits 11..4 are custom events 8..1
// - bit3 port b, bit2 port a, bit1 monitor
// - bit0 captures inverted temperature alert
// - everything runs on one clock
// - reset active low
// - reset clears all registers to zero
// - enabled rising edge gives one-cycle pulse
// - only enabled sources reach the output
// - latching ignores enable bits
// - held-high source gives no repeat pulse
// - status shows present source levels
// - latch holds until software clears it
// - registers reached as AXI4-Lite slave
// - eight custom event inputs accepted
// - read-only live status at 0x2C
// - status rising sets matching latch
// - per-source enable bit, one enables
`timescale 1ns/1ns
`include "bilu_regs.vh"
module bilu_top (
  // clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // interrupt sources
  input  wire        custom_event_one,
  input  wire        custom_event_two,
  input  wire        custom_event_three,
  input  wire        custom_event_four,
  input  wire        custom_event_five,
  input  wire        custom_event_six,
  input  wire        custom_event_seven,
  input  wire        custom_event_eight,
  input  wire        serial_bus_port_a_event,
  input  wire        serial_bus_port_b_event,
  input  wire        sysMonEvent,
  input  wire        extTempAlert_b,
  // interrupt output
  output reg         irq,
  // axi4-lite write address
  input  wire [5:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [5:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // byte offsets of the three mapped registers
  localparam [5:0]  OFS_ENABLE = `BILU_OFS_ENABLE;
  localparam [5:0]  OFS_STATUS = `BILU_OFS_STATUS;
  localparam [5:0]  OFS_LATCH  = `BILU_OFS_LATCH;

  // sources, captured state and enables
  wire [11:0] srcLevel;
  reg  [11:0] status_reg;
  reg  [11:0] latch_reg;
  wire [11:0] latch_next;
  reg  [11:0] enable_reg;
  wire [11:0] enable_next;
  wire [11:0] risePulse;
  wire [11:0] fireBit;
  wire        irq_next;

  // write channel
  reg  [5:0]  wrAddr_reg;
  reg  [31:0] wrData_reg;
  reg  [3:0]  wrStrb_reg;
  reg         haveAddr_reg;
  reg         haveData_reg;
  wire        doWrite;
  wire        wrHitLatch;
  wire        wrHitEnable;
  wire        wrHitStatus;
  wire        wrLatch;
  wire        wrEnable;
  reg  [1:0]  wrResp;

  // read channel
  wire        arTaken;
  reg  [31:0] rdValue;
  reg  [1:0]  rdResp;

  // bit positions are fixed by the source order
  assign srcLevel[11] = custom_event_eight;
  assign srcLevel[10] = custom_event_seven;
  assign srcLevel[9]  = custom_event_six;
  assign srcLevel[8]  = custom_event_five;
  assign srcLevel[7]  = custom_event_four;
  assign srcLevel[6]  = custom_event_three;
  assign srcLevel[5]  = custom_event_two;
  assign srcLevel[4]  = custom_event_one;
  assign srcLevel[3]  = serial_bus_port_b_event;
  assign srcLevel[2]  = serial_bus_port_a_event;
  assign srcLevel[1]  = sysMonEvent;
  assign srcLevel[0]  = ~extTempAlert_b;

  // edge taken against last sampled level, so a held source stays quiet
  assign risePulse = srcLevel & ~status_reg;

  // decode of the captured write address
  assign wrHitLatch  = (wrAddr_reg[5:2] == OFS_LATCH[5:2]);
  assign wrHitEnable = (wrAddr_reg[5:2] == OFS_ENABLE[5:2]);
  assign wrHitStatus = (wrAddr_reg[5:2] == OFS_STATUS[5:2]);
  // a write needs both halves and a free response slot
  assign doWrite     = haveAddr_reg && haveData_reg && !s_axi_bvalid;
  assign wrLatch     = doWrite && wrHitLatch;
  assign wrEnable    = doWrite && wrHitEnable;

  // one slice per source; strobe lane 0 covers bits 7:0, lane 1 bits 11:8
  genvar gi;
  generate
    for (gi = 0; gi < `BILU_NSRC; gi = gi + 1) begin : g_src
      wire laneOn;
      wire setHit;
      wire clearHit;
      wire keepBit;

      assign laneOn          = wrStrb_reg[gi / 8];
      assign setHit          = risePulse[gi];
      assign clearHit        = wrLatch && laneOn && wrData_reg[gi];
      assign keepBit         = latch_reg[gi] && !clearHit;
      // a new edge wins over a clear in the same cycle
      assign latch_next[gi]  = setHit || keepBit;
      assign enable_next[gi] = (wrEnable && laneOn) ? wrData_reg[gi] : enable_reg[gi];
      assign fireBit[gi]     = setHit && enable_reg[gi];
    end
  endgenerate

  // address is held until the paired data has landed
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b0;
      haveAddr_reg  <= 1'b0;
      wrAddr_reg    <= 6'h00;
    end else begin
      s_axi_awready <= 1'b0;
      if (doWrite) begin
        haveAddr_reg <= 1'b0;
      end else if (s_axi_awvalid && !haveAddr_reg && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        haveAddr_reg  <= 1'b1;
        wrAddr_reg    <= s_axi_awaddr;
      end
    end
  end

  // data is held until the paired address has landed
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_wready <= 1'b0;
      haveData_reg <= 1'b0;
      wrData_reg   <= 32'h00000000;
      wrStrb_reg   <= 4'h0;
    end else begin
      s_axi_wready <= 1'b0;
      if (doWrite) begin
        haveData_reg <= 1'b0;
      end else if (s_axi_wvalid && !haveData_reg && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
        haveData_reg <= 1'b1;
        wrData_reg   <= s_axi_wdata;
        wrStrb_reg   <= s_axi_wstrb;
      end
    end
  end

  // status is read-only; writing it is harmless and answers OKAY
  always @* begin
    wrResp = `BILU_RESP_SLVERR;
    if (wrHitLatch) begin
      wrResp = `BILU_RESP_OKAY;
    end else if (wrHitEnable) begin
      wrResp = `BILU_RESP_OKAY;
    end else if (wrHitStatus) begin
      wrResp = `BILU_RESP_OKAY;
    end
  end

  // response stands until the master takes it
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `BILU_RESP_OKAY;
    end else begin
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrResp;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // live level of every source
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= `BILU_RESET_VAL;
    end else begin
      status_reg <= srcLevel;
    end
  end

  // latched occurrences, cleared only by software
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_reg <= `BILU_RESET_VAL;
    end else begin
      latch_reg <= latch_next;
    end
  end

  // per-source enables
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_reg <= `BILU_RESET_VAL;
    end else begin
      enable_reg <= enable_next;
    end
  end

  // only enabled sources reach the output
  assign irq_next = |fireBit;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_next;
    end
  end

  // reserved bits and unmapped words read as zero
  always @* begin
    rdValue = 32'h00000000;
    rdResp  = `BILU_RESP_OKAY;
    if (s_axi_araddr[5:2] == OFS_LATCH[5:2]) begin
      rdValue[11:0] = latch_reg;
    end else if (s_axi_araddr[5:2] == OFS_STATUS[5:2]) begin
      rdValue[11:0] = status_reg;
    end else if (s_axi_araddr[5:2] == OFS_ENABLE[5:2]) begin
      rdValue[11:0] = enable_reg;
    end else begin
      rdResp = `BILU_RESP_SLVERR;
    end
  end

  // arready leads rvalid by one cycle, so data never precedes the handshake
  assign arTaken = s_axi_arvalid && s_axi_arready;

  // a new address is taken only while no read data is waiting
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // data stands unchanged until rready
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `BILU_RESP_OKAY;
    end else begin
      if (arTaken) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdValue;
        s_axi_rresp  <= rdResp;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // bilu_top

// [bilu_asserts.sv]
// checker: bus handshakes and irq pulse of the latch unit
// assumes bind to bilu_top, one clock domain
`timescale 1ns/1ns
module bilu_asserts (
  // clock and reset
  input wire logic        clk, rst_b,
  // watched outputs
  input wire logic        irq, s_axi_awready, s_axi_wready, s_axi_bvalid,
  input wire logic        s_axi_arready, s_axi_rvalid,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  // master handshake
  input wire logic        s_axi_bready, s_axi_rready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_irqPulse; irq |=> !irq; endproperty
  a_irqPulse: assert property (p_irqPulse) else $error("irq too wide");
  property p_bHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bHold: assert property (p_bHold) else $error("bvalid dropped");
  property p_rHold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rHold: assert property (p_rHold) else $error("read data not held");
  property p_arAns; s_axi_arready |=> s_axi_rvalid; endproperty
  a_arAns: assert property (p_arAns) else $error("no read data with arready");
  property p_wAns; s_axi_awready && s_axi_wready |=> s_axi_bvalid; endproperty
  a_wAns: assert property (p_wAns) else $error("no write response");
  property p_awPulse; s_axi_awready |=> !s_axi_awready; endproperty
  a_awPulse: assert property (p_awPulse) else $error("awready too wide");
  property p_errZero; s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0; endproperty
  a_errZero: assert property (p_errZero) else $error("error read not zero");
  property p_rDone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rDone: assert property (p_rDone) else $error("rvalid after handshake");
  c_irq: cover property (irq);
  c_slvErr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_wrDone: cover property (s_axi_bvalid && s_axi_bready);
endmodule // bilu_asserts
bind bilu_top bilu_asserts u_bilu_asserts (.*);

// [bilu_axi_master.sv]
// behavioural register-bus master for the latch unit
// assumes answers within 20 cycles; drives on falling edges
`timescale 1ns/1ns
module bilu_axi_master (
  // clock
  input  wire        clk,
  // requests
  output reg  [5:0]  s_axi_awaddr, s_axi_araddr,
  output reg  [31:0] s_axi_wdata,
  output reg  [3:0]  s_axi_wstrb,
  output reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
  // answers
  input  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid,
  input  wire [1:0]  s_axi_bresp, s_axi_rresp,
  input  wire [31:0] s_axi_rdata
);
  initial {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 48'h0;
  initial {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
  task wr(input [5:0] a, input [31:0] d, output [1:0] r);
    reg awHs;
    reg wHs;
    @(negedge clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} = {a, d, 4'hF};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h7;
    r = 2'h3;
    repeat (20) begin
      @(posedge clk);
      // a handshake counts only at the edge where ready is sampled high
      awHs = s_axi_awvalid && s_axi_awready;
      wHs = s_axi_wvalid && s_axi_wready;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        break;
      end
      @(negedge clk);
      // released lines show inverted data, never the old value
      if (awHs) {s_axi_awvalid, s_axi_awaddr} = {1'b0, ~s_axi_awaddr};
      if (wHs) {s_axi_wvalid, s_axi_wdata} = {1'b0, ~s_axi_wdata};
    end
    @(negedge clk) s_axi_bready = 1'b0;
  endtask
  task rd(input [5:0] a, output [31:0] d, output [1:0] r);
    reg arHs;
    @(negedge clk) {s_axi_araddr, s_axi_arvalid, s_axi_rready} = {a, 2'h3};
    {d, r} = {32'hFFFFFFFF, 2'h3};
    repeat (20) begin
      @(posedge clk);
      arHs = s_axi_arvalid && s_axi_arready;
      if (s_axi_rvalid) begin
        {d, r} = {s_axi_rdata, s_axi_rresp};
        break;
      end
      @(negedge clk);
      if (arHs) {s_axi_araddr, s_axi_arvalid} = {~s_axi_araddr, 1'b0};
    end
    @(negedge clk) {s_axi_araddr, s_axi_arvalid, s_axi_rready} = {~a, 2'h0};
  endtask
endmodule // bilu_axi_master

// [bilu_top_test.sv]
// bench: table of source pulses, then clear, bus and reset corners
// assumes bilu_top and bilu_axi_master; inputs change on falling edges
`timescale 1ns/1ns
`include "bilu_regs.vh"
module bilu_top_test;
  reg         clk = 1'b0;
  reg         rst_b = 1'b0;
  reg  [11:0] srcVec = 12'h000;
  wire        irq, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  wire        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  wire [5:0]  s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0]  s_axi_wstrb;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  integer     n_errors = 0, samples_checked = 0, nIrq = 0, cyc = 0, i;
  reg  [31:0] rdVal;
  reg  [1:0]  resp;
  // enable, sources raised, pulses expected
  reg  [24:0] rows [0:4] = '{{12'h010, 12'h010, 1'b1}, {12'h000, 12'h800, 1'b0},
    {12'h001, 12'h00F, 1'b1}, {12'hFE0, 12'h01E, 1'b0}, {12'hFFF, 12'hFF0, 1'b1}};
  bilu_top u_bilu_top (.*, .custom_event_one(srcVec[4]), .custom_event_two(srcVec[5]),
    .custom_event_three(srcVec[6]), .custom_event_four(srcVec[7]),
    .custom_event_five(srcVec[8]), .custom_event_six(srcVec[9]),
    .custom_event_seven(srcVec[10]), .custom_event_eight(srcVec[11]),
    .serial_bus_port_a_event(srcVec[2]), .serial_bus_port_b_event(srcVec[3]),
    .sysMonEvent(srcVec[1]), .extTempAlert_b(~srcVec[0]));
  bilu_axi_master u_bilu_axi_master (.*);
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (irq === 1'b1) nIrq = nIrq + 1;
    if (cyc == 3000) begin
      n_errors = n_errors + 1;
      stop_test;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input [5:0] a, input [31:0] d);
    u_bilu_axi_master.wr(a, d, resp);
  endtask
  task rdc(input [5:0] a, input [31:0] exp);
    u_bilu_axi_master.rd(a, rdVal, resp);
    chk(rdVal, exp);
  endtask
  task stop_test;
    $display("compares %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    rdc(`BILU_OFS_LATCH, 0);
    rdc(`BILU_OFS_ENABLE, 0);
    for (i = 0; i < 5; i = i + 1) begin
      wr(`BILU_OFS_LATCH, 32'hFFF);
      wr(`BILU_OFS_ENABLE, rows[i][24:13]);
      rdc(`BILU_OFS_ENABLE, rows[i][24:13]);
      nIrq = 0;
      @(negedge clk) srcVec = rows[i][12:1];
      rdc(`BILU_OFS_STATUS, rows[i][12:1]);
      chk(nIrq, rows[i][0]);
      @(negedge clk) srcVec = 12'h000;
      rdc(`BILU_OFS_LATCH, rows[i][12:1]);
      $display("row %0d done", i);
    end
    wr(`BILU_OFS_LATCH, 32'hFFFFF010);
    rdc(`BILU_OFS_LATCH, 32'hFE0);
    wr(`BILU_OFS_STATUS, 32'hFFF);
    chk(resp, `BILU_RESP_OKAY);
    wr(6'h3C, 32'hFFF);
    chk(resp, `BILU_RESP_SLVERR);
    rdc(6'h3C, 0);
    chk(resp, `BILU_RESP_SLVERR);
    nIrq = 0;
    @(negedge clk) srcVec = 12'h010;
    wr(`BILU_OFS_LATCH, 32'hFFF);
    rdc(`BILU_OFS_LATCH, 0);
    chk(nIrq, 1);
    $display("held source done");
    @(negedge clk) {rst_b, srcVec} = 13'h0000;
    @(negedge clk) rst_b = 1'b1;
    rdc(`BILU_OFS_LATCH, 0);
    rdc(`BILU_OFS_ENABLE, 0);
    $display("mid-run reset done");
    stop_test;
  end
endmodule // bilu_top_test
